// *** rtl/sleep_strap_pkg.sv ***
// Package of constants, types and encodings for the strap-configured sleep logic
// Operation
// - Low enable strap enables automatic sleep
// - After latch, enable bias drops to run
// - Program strap picks exit duty; enable strap picks entry
// - Program bias off once selection latched
// - Enable strap level selects lookup table
// - Lower enable: entry 40, exit 80/75/65/60
// - Higher enable: entry 25, exit 75/70/60/55
// - Open enable pin disables sleep, latched
// - Sleep disabled: no light-load duty entry
// - Disabled: still sleep on stop or enable low
// - Resume only when duty exceeds exit threshold
// - Open enable: exit 80/75/65/0 percent
// - Latch at supply turn-on, hold while valid
// - Enter sleep after 512 low-duty cycles
// - Enable low stops; resume needs enable high and duty above exit
package sleep_strap_pkg;
  localparam logic [1:0] STRAP_SHORT = 2'h0;
  localparam logic [1:0] STRAP_LOW = 2'h1;
  localparam logic [1:0] STRAP_MID = 2'h2;
  localparam logic [1:0] STRAP_OPEN = 2'h3;
  localparam int TIME_W = 16;
  localparam int PCT_W = 7;
  localparam logic [PCT_W-1:0] ENTRY_LOW_EN = 7'h28;
  localparam logic [PCT_W-1:0] ENTRY_HIGH_EN = 7'h19;
  localparam logic [PCT_W-1:0] EXIT_LOW_SHORT = 7'h50;
  localparam logic [PCT_W-1:0] EXIT_LOW_LOW = 7'h4B;
  localparam logic [PCT_W-1:0] EXIT_LOW_MID = 7'h41;
  localparam logic [PCT_W-1:0] EXIT_LOW_OPEN = 7'h3C;
  localparam logic [PCT_W-1:0] EXIT_HIGH_SHORT = 7'h4B;
  localparam logic [PCT_W-1:0] EXIT_HIGH_LOW = 7'h46;
  localparam logic [PCT_W-1:0] EXIT_HIGH_MID = 7'h3C;
  localparam logic [PCT_W-1:0] EXIT_HIGH_OPEN = 7'h37;
  localparam logic [PCT_W-1:0] BURST_EXIT_SHORT = 7'h50;
  localparam logic [PCT_W-1:0] BURST_EXIT_LOW = 7'h4B;
  localparam logic [PCT_W-1:0] BURST_EXIT_MID = 7'h41;
  localparam logic [PCT_W-1:0] BURST_EXIT_OPEN = 7'h00;
  localparam logic [PCT_W-1:0] PCT_FULL = 7'h64;
  localparam int CONFIRM_CYCLES = 512;
  localparam int CONFIRM_W = 10;
  localparam logic [CONFIRM_W-1:0] CONFIRM_LAST = 10'(CONFIRM_CYCLES - 1);

  typedef struct packed {
    logic sleep_enabled;
    logic high_table;
    logic [PCT_W-1:0] entry_duty;
    logic [PCT_W-1:0] exit_duty;
  } strap_cfg_s;

  typedef struct packed {
    logic valid;
    logic [TIME_W-1:0] conduction;
    logic [TIME_W-1:0] half_period;
  } duty_sample_s;

  typedef enum logic [3:0] {
    ST_STARTUP = 4'h1,
    ST_RUN = 4'h2,
    ST_SLEEP = 4'h4,
    ST_OFF = 4'h8
  } mode_e;
endpackage

// *** rtl/strap_table.sv ***
// Strap lookup: maps the two strap codes to a sleep configuration
module strap_table (
  input wire logic [1:0] enable_code_i,
  input wire logic [1:0] threshold_code_i,
  output sleep_strap_pkg::strap_cfg_s cfg_o
);
  import sleep_strap_pkg::*;

  always_comb begin
    cfg_o = '0;
    cfg_o.sleep_enabled = (enable_code_i != STRAP_OPEN);
    cfg_o.high_table = (enable_code_i == STRAP_MID);
    case (enable_code_i)
      STRAP_SHORT, STRAP_LOW: begin
        cfg_o.entry_duty = ENTRY_LOW_EN;
        case (threshold_code_i)
          STRAP_SHORT: cfg_o.exit_duty = EXIT_LOW_SHORT;
          STRAP_LOW: cfg_o.exit_duty = EXIT_LOW_LOW;
          STRAP_MID: cfg_o.exit_duty = EXIT_LOW_MID;
          default: cfg_o.exit_duty = EXIT_LOW_OPEN;
        endcase
      end
      STRAP_MID: begin
        cfg_o.entry_duty = ENTRY_HIGH_EN;
        case (threshold_code_i)
          STRAP_SHORT: cfg_o.exit_duty = EXIT_HIGH_SHORT;
          STRAP_LOW: cfg_o.exit_duty = EXIT_HIGH_LOW;
          STRAP_MID: cfg_o.exit_duty = EXIT_HIGH_MID;
          default: cfg_o.exit_duty = EXIT_HIGH_OPEN;
        endcase
      end
      default: begin
        cfg_o.entry_duty = '0;
        case (threshold_code_i)
          STRAP_SHORT: cfg_o.exit_duty = BURST_EXIT_SHORT;
          STRAP_LOW: cfg_o.exit_duty = BURST_EXIT_LOW;
          STRAP_MID: cfg_o.exit_duty = BURST_EXIT_MID;
          default: cfg_o.exit_duty = BURST_EXIT_OPEN;
        endcase
      end
    endcase
  end
endmodule

// *** rtl/duty_compare.sv ***
// Duty comparator: conduction share of a half period against a percentage
module duty_compare (
  input wire logic [15:0] conduction_i,
  input wire logic [15:0] half_period_i,
  input wire logic [6:0] pct_i,
  output logic above_o,
  output logic below_o
);
  import sleep_strap_pkg::*;
  logic [22:0] lhs;
  logic [22:0] rhs;

  // Cross-multiplied so no divider is needed
  always_comb begin
    lhs = 23'(conduction_i) * 23'(PCT_FULL);
    rhs = 23'(half_period_i) * 23'(pct_i);
    above_o = lhs > rhs;
    below_o = lhs < rhs;
  end
endmodule

// *** rtl/sleep_mode_strap_config.sv ***
// Top of the strap-configured sleep and low-consumption control
module sleep_mode_strap_config (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic strap_strobe_i,
  input wire logic [1:0] enable_strap_code_i,
  input wire logic [1:0] threshold_strap_code_i,
  input wire logic enable_pin_high_i,
  input wire logic primary_stopped_i,
  input wire sleep_strap_pkg::duty_sample_s duty_i,
  output logic enable_bias_startup_o,
  output logic threshold_pin_bias_source_o,
  output logic config_latched_o,
  output sleep_strap_pkg::strap_cfg_s cfg_o,
  output logic [6:0] burst_exit_duty_o,
  output logic gate_drive_enable_o,
  output logic low_consumption_o
);
  import sleep_strap_pkg::*;

  strap_cfg_s table_cfg;
  strap_cfg_s cfg;
  strap_cfg_s next_cfg;
  logic latched;
  logic next_latched;
  mode_e mode;
  mode_e next_mode;
  logic [CONFIRM_W-1:0] low_count;
  logic [CONFIRM_W-1:0] next_low_count;
  logic entry_below;
  logic exit_above;

  strap_table u_table (
    .enable_code_i(enable_strap_code_i),
    .threshold_code_i(threshold_strap_code_i),
    .cfg_o(table_cfg)
  );

  duty_compare u_entry (
    .conduction_i(duty_i.conduction),
    .half_period_i(duty_i.half_period),
    .pct_i(cfg.entry_duty),
    .above_o(),
    .below_o(entry_below)
  );

  duty_compare u_exit (
    .conduction_i(duty_i.conduction),
    .half_period_i(duty_i.half_period),
    .pct_i(cfg.exit_duty),
    .above_o(exit_above),
    .below_o()
  );

  // Straps read once at the first strobe after reset; reset is the supply monitor
  always_comb begin
    next_cfg = cfg;
    next_latched = latched;
    if (!latched && strap_strobe_i) begin
      next_cfg = table_cfg;
      next_latched = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      cfg <= '0;
      latched <= 1'b0;
    end else begin
      cfg <= next_cfg;
      latched <= next_latched;
    end
  end

  always_comb begin
    next_mode = mode;
    next_low_count = low_count;
    case (mode)
      ST_STARTUP: begin
        if (latched) begin
          next_mode = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!enable_pin_high_i) begin
          next_mode = ST_OFF;
          next_low_count = '0;
        end else if (!cfg.sleep_enabled && primary_stopped_i) begin
          next_mode = ST_SLEEP;
        end else if (duty_i.valid && cfg.sleep_enabled) begin
          if (!entry_below) begin
            next_low_count = '0;
          end else if (low_count == CONFIRM_LAST) begin
            next_mode = ST_SLEEP;
            next_low_count = '0;
          end else begin
            next_low_count = low_count + 10'h001;
          end
        end
      end
      ST_SLEEP, ST_OFF: begin
        // Cannot leave while enable pin is still held low
        if (!enable_pin_high_i) begin
          next_mode = ST_OFF;
        end else if (duty_i.valid && exit_above && !primary_stopped_i) begin
          next_mode = ST_RUN;
          next_low_count = '0;
        end
      end
      default: begin
        next_mode = ST_STARTUP;
        next_low_count = '0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      mode <= ST_STARTUP;
      low_count <= '0;
    end else begin
      mode <= next_mode;
      low_count <= next_low_count;
    end
  end

  // Remote switch must stay open until the latch; nothing here checks it
  always_comb begin
    enable_bias_startup_o = !latched;
    threshold_pin_bias_source_o = !latched;
    config_latched_o = latched;
    cfg_o = cfg;
    burst_exit_duty_o = cfg.sleep_enabled ? '0 : cfg.exit_duty;
    gate_drive_enable_o = (mode == ST_RUN);
    low_consumption_o = (mode == ST_SLEEP) || (mode == ST_OFF);
  end
endmodule

// *** tb/strap_partner_model.sv ***
// External strap resistors and remote switch on the enable pin
module strap_partner_model (
  input wire logic startup_i,
  input wire logic strobe_i,
  input wire logic switch_closed_i,
  input wire logic [1:0] en_sel_i,
  input wire logic [1:0] pg_sel_i,
  output logic [1:0] enable_strap_code_o,
  output logic [1:0] threshold_strap_code_o,
  output logic enable_pin_high_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Codes mean nothing off strobe, so garble them
  assign enable_strap_code_o = strobe_i ? en_sel_i : ~en_sel_i;
  assign threshold_strap_code_o = strobe_i ? pg_sel_i : ~pg_sel_i;
  assign enable_pin_high_o = !(switch_closed_i && !startup_i);
endmodule

// *** tb/sleep_mode_strap_config_properties.sv ***
// Checker of the strap-configured sleep control
module sleep_mode_strap_config_properties (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic strap_strobe_i,
  input wire logic enable_pin_high_i,
  input wire logic primary_stopped_i,
  input wire sleep_strap_pkg::duty_sample_s duty_i,
  input wire logic enable_bias_startup_o,
  input wire logic threshold_pin_bias_source_o,
  input wire logic config_latched_o,
  input wire sleep_strap_pkg::strap_cfg_s cfg_o,
  input wire logic [6:0] burst_exit_duty_o,
  input wire logic gate_drive_enable_o,
  input wire logic low_consumption_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import sleep_strap_pkg::*;
  logic above;
  logic dis;
  logic g;
  assign g = gate_drive_enable_o;
  assign above = duty_i.valid && enable_pin_high_i &&
    32'(duty_i.conduction) * 100 > 32'(duty_i.half_period) * 32'(cfg_o.exit_duty);
  assign dis = config_latched_o && !cfg_o.sleep_enabled;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  bias_drop_a: assert property (
    config_latched_o |-> !enable_bias_startup_o && !threshold_pin_bias_source_o) else $error("bias");
  latch_take_a: assert property (
    strap_strobe_i && !config_latched_o |=> config_latched_o) else $error("latch");
  cfg_hold_a: assert property (
    config_latched_o |=> config_latched_o && $stable(cfg_o)) else $error("cfg moved");
  no_duty_sleep_a: assert property (
    dis && g && enable_pin_high_i && !primary_stopped_i |=> g) else $error("duty sleep");
  stop_sleep_a: assert property (
    dis && g && primary_stopped_i |=> low_consumption_o) else $error("stop");
  en_off_a: assert property (
    g && !enable_pin_high_i |=> low_consumption_o && !g) else $error("en off");
  burst_exit_a: assert property (
    config_latched_o |-> burst_exit_duty_o == (cfg_o.sleep_enabled ? 7'h00 : cfg_o.exit_duty))
    else $error("burst");
  entry_pick_a: assert property (
    config_latched_o && cfg_o.sleep_enabled |->
    cfg_o.entry_duty == (cfg_o.high_table ? ENTRY_HIGH_EN : ENTRY_LOW_EN)) else $error("entry");
  resume_gate_a: assert property (
    $rose(g) && $past(low_consumption_o) |-> $past(above)) else $error("resume");
  cover property ($rose(low_consumption_o) && cfg_o.sleep_enabled);
  cover property ($rose(g) && $past(low_consumption_o));
  cover property (dis && primary_stopped_i && g);
endmodule
bind sleep_mode_strap_config sleep_mode_strap_config_properties i_props (.clk_sys_i, .reset_n_i,
  .strap_strobe_i, .enable_pin_high_i, .primary_stopped_i, .duty_i, .enable_bias_startup_o,
  .threshold_pin_bias_source_o, .config_latched_o, .cfg_o, .burst_exit_duty_o,
  .gate_drive_enable_o, .low_consumption_o);

// *** tb/sleep_mode_strap_config_bench.sv ***
// Self-checking bench of the strap-configured sleep control
module sleep_mode_strap_config_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import sleep_strap_pkg::*;
  logic clk_sys_i = 1'b0, reset_n_i = 1'b0, strap_strobe_i = 1'b0, primary_stopped_i = 1'b0;
  logic sw = 1'b0;
  logic [1:0] en_sel = 2'h0, pg_sel = 2'h0, en_code, pg_code;
  logic en_high, bias_en, bias_pg, latched, gate, low;
  logic [6:0] burst;
  logic [6:0] xt [3][4] = '{'{7'h50, 7'h4B, 7'h41, 7'h3C}, '{7'h4B, 7'h46, 7'h3C, 7'h37},
    '{7'h50, 7'h4B, 7'h41, 7'h00}};
  duty_sample_s duty_i = '0;
  strap_cfg_s cfg;
  int mismatches = 0, samples_checked = 0;
  strap_partner_model i_strap_partner_model (.startup_i(!latched), .strobe_i(strap_strobe_i),
    .switch_closed_i(sw), .en_sel_i(en_sel), .pg_sel_i(pg_sel), .enable_strap_code_o(en_code),
    .threshold_strap_code_o(pg_code), .enable_pin_high_o(en_high));
  sleep_mode_strap_config i_sleep_mode_strap_config (.clk_sys_i, .reset_n_i, .strap_strobe_i,
    .enable_strap_code_i(en_code), .threshold_strap_code_i(pg_code), .enable_pin_high_i(en_high),
    .primary_stopped_i, .duty_i, .enable_bias_startup_o(bias_en),
    .threshold_pin_bias_source_o(bias_pg), .config_latched_o(latched), .cfg_o(cfg),
    .burst_exit_duty_o(burst), .gate_drive_enable_o(gate), .low_consumption_o(low));
  initial begin
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic boot(input logic [1:0] e, input logic [1:0] p);
    @(negedge clk_sys_i);
    reset_n_i = 0;
    en_sel = e;
    pg_sel = p;
    repeat (2) @(negedge clk_sys_i);
    reset_n_i = 1;
    strap_strobe_i = 1;
    repeat (3) @(negedge clk_sys_i);
    strap_strobe_i = 0;
  endtask
  // Held samples count as back-to-back valid half periods of 100 clocks
  task automatic smp(input logic [15:0] c, input int n);
    duty_i = {1'b1, c, 16'h0064};
    repeat (n) @(negedge clk_sys_i);
    duty_i = '0;
    @(negedge clk_sys_i);
  endtask
  task automatic t_table();
    for (int e = 0; e < 4; e++) for (int p = 0; p < 4; p++) begin
      boot(e[1:0], p[1:0]);
      @(negedge clk_sys_i);
      pg_sel = ~p[1:0];
      strap_strobe_i = 1;
      repeat (2) @(negedge clk_sys_i);
      strap_strobe_i = 0;
      chk(cfg.sleep_enabled === (e != 3), "sleep enable");
      chk(cfg.high_table === (e == 2), "table select");
      chk(e == 3 || cfg.entry_duty === (e == 2 ? 7'h19 : 7'h28), "entry");
      chk(cfg.exit_duty === xt[e < 2 ? 0 : e - 1][p], "exit");
      chk(burst === (e == 3 ? xt[2][p] : 7'h00), "burst exit");
      chk({bias_en, bias_pg, latched} === 3'b001, "biases");
    end
    $display("t_table done");
  endtask
  task automatic t_sleep();
    boot(2'h1, 2'h0);
    smp(16'h0027, 300);
    smp(16'h0028, 1);
    chk(gate === 1'b1 && low === 1'b0, "sleep at entry threshold");
    smp(16'h0027, 511);
    chk(gate === 1'b1 && low === 1'b0, "early sleep");
    smp(16'h0027, 1);
    chk(gate === 1'b0 && low === 1'b1, "no sleep");
    smp(16'h0050, 1);
    chk(low === 1'b1, "exit at threshold");
    smp(16'h0051, 1);
    chk(gate === 1'b1, "no exit");
    $display("t_sleep done");
  endtask
  task automatic t_disabled();
    boot(2'h3, 2'h3);
    smp(16'h0001, 600);
    chk(gate === 1'b1, "light load sleep");
    primary_stopped_i = 1;
    @(negedge clk_sys_i);
    chk(low === 1'b1, "stop ignored");
    primary_stopped_i = 0;
    smp(16'h0000, 1);
    chk(low === 1'b1, "zero duty resumed");
    smp(16'h0001, 1);
    chk(gate === 1'b1, "no resume");
    sw = 1;
    @(negedge clk_sys_i);
    chk(low === 1'b1 && gate === 1'b0, "enable low");
    sw = 0;
    smp(16'h0001, 1);
    chk(gate === 1'b1, "enable high");
    $display("t_disabled done");
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #1000000;
    mismatches++;
    end_of_test();
  end
  initial begin
    repeat (20) @(negedge clk_sys_i);
    t_table();
    t_sleep();
    t_disabled();
    end_of_test();
  end
endmodule
